// File: hw/afe_switch_ctrl.sv
// Functional notes
// - Excitation on and sample-hold off: excitation path live, sampling switches open.
// - Excite strobe high in excitation: selected channel grounded, common to mid-voltage.
// - Excitation happens only while the oscillator-release strobe is high.
// - Only the selected channel is grounded and routed; damping and sampling switches act on all channels.
// - Excite strobe low releases the selected channel from ground.
// - Mid-voltage generator on when its enable bit is one, unless sample-hold is set and excitation is clear.
// - Sample-hold mode: sampling enabled, excitation and mid-voltage generator off.
// - Sample mode, excite high: common grounded, all sampling switches closed.
// - Sample mode, excite low: all sampling switches open, common released.
// - Held channels reach the comparator one at a time by channel select.
// - Direct-input bit routes the direct pins to the comparator instead.
// - Direct-input bit overrides; otherwise exactly one of the excitation and sample-hold bits picks the path, else off.
`timescale 1ns/1ps
module afe_switch_ctrl
    import afe_switch_pkg::*;
#(
    parameter int SETTLE_CYCLES = MID_SETTLE_CYCLES
)
(
    input wire logic CLK, // 20 MHz clock
    input wire logic SYS_RST, // Synchronous reset, active high
    input wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR, // Write address
    input wire logic S_AXI_AWVALID, // Write address valid
    output logic S_AXI_AWREADY, // Write address ready
    input wire logic [31:0] S_AXI_WDATA, // Write data
    input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes
    input wire logic S_AXI_WVALID, // Write data valid
    output logic S_AXI_WREADY, // Write data ready
    output logic [1:0] S_AXI_BRESP, // Write response
    output logic S_AXI_BVALID, // Write response valid
    input wire logic S_AXI_BREADY, // Write response ready
    input wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR, // Read address
    input wire logic S_AXI_ARVALID, // Read address valid
    output logic S_AXI_ARREADY, // Read address ready
    output logic [31:0] S_AXI_RDATA, // Read data
    output logic [1:0] S_AXI_RRESP, // Read response
    output logic S_AXI_RVALID, // Read data valid
    input wire logic S_AXI_RREADY, // Read data ready
    input wire logic EXCITE_STROBE, // Excite / sample strobe
    input wire logic OSCILLATOR_RELEASE_STROBE, // Sensors free to oscillate
    input wire logic [CH_SEL_W-1:0] CHANNEL_SELECT_STROBE, // Channel number
    output logic [CH_NUM-1:0] CH_TO_GROUND, // Channel input to analog ground
    output logic [CH_NUM-1:0] CH_DAMP, // Channel shorted for damping
    output logic [CH_NUM-1:0] SAMPLE_CLOSE, // Sampling switches closed
    output logic [CH_NUM-1:0] CH_TO_COMPARATOR, // Sensor channel to comparator
    output logic [CH_NUM-1:0] DIRECT_TO_COMPARATOR, // Direct input to comparator
    output logic COM_TO_MID, // Common return to mid-voltage source
    output logic COM_TO_GROUND, // Common return to analog ground
    output logic MID_VOLTAGE_ON // Mid-voltage generator on
);

    localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

    function automatic logic addr_is(input logic [AXI_ADDR_W-1:0] addr,
                                     input logic [7:0] offset);
        addr_is = (addr[AXI_ADDR_W-1:2] == offset[AXI_ADDR_W-1:2]);
    endfunction

    logic [CTRL_W-1:0] ctrl_q;
    logic aw_held_q;
    logic w_held_q;
    logic [AXI_ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_go;
    logic [31:0] status_word;

    afe_mode_type mode_c;
    logic [CH_NUM-1:0] ground_c;
    logic [CH_NUM-1:0] damp_c;
    logic [CH_NUM-1:0] sample_c;
    logic [CH_NUM-1:0] route_c;
    logic [CH_NUM-1:0] direct_c;
    logic com_mid_c;
    logic com_gnd_c;
    logic mid_on_c;

    afe_mode_type mode_q;
    logic [CH_NUM-1:0] ground_q;
    logic [CH_NUM-1:0] damp_q;
    logic [CH_NUM-1:0] sample_q;
    logic [CH_NUM-1:0] route_q;
    logic [CH_NUM-1:0] direct_q;
    logic com_mid_q;
    logic com_gnd_q;
    logic mid_on_q;
    logic [CNT_W-1:0] settle_cnt_q;
    logic settled_q;

    // Strobes come from the sequencer on this clock, so they are not synchronised
    afe_switch_decode u_decode
    (
        .excitation_enable(ctrl_q[CTRL_EXC_BIT]),
        .sample_hold_select(ctrl_q[CTRL_SHS_BIT]),
        .mid_voltage_enable(ctrl_q[CTRL_MID_BIT]),
        .direct_input_select(ctrl_q[CTRL_DIR_BIT]),
        .excite_strobe(EXCITE_STROBE),
        .oscillator_release_strobe(OSCILLATOR_RELEASE_STROBE),
        .channel_select_strobe(CHANNEL_SELECT_STROBE),
        .mode(mode_c),
        .ch_ground(ground_c),
        .ch_damp(damp_c),
        .sample_close(sample_c),
        .ch_route(route_c),
        .direct_route(direct_c),
        .com_to_mid(com_mid_c),
        .com_to_ground(com_gnd_c),
        .mid_on(mid_on_c)
    );

    // Switch drives are registered so no decode glitch reaches the analog side
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            mode_q <= MODE_OFF;
            ground_q <= '0;
            damp_q <= '0;
            sample_q <= '0;
            route_q <= '0;
            direct_q <= '0;
            com_mid_q <= 1'b0;
            com_gnd_q <= 1'b0;
            mid_on_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_c;
            ground_q <= ground_c;
            damp_q <= damp_c;
            sample_q <= sample_c;
            route_q <= route_c;
            direct_q <= direct_c;
            com_mid_q <= com_mid_c;
            com_gnd_q <= com_gnd_c;
            mid_on_q <= mid_on_c;
        end
    end

    // Settling timer only reports; switching does not wait for it
    always_ff @(posedge CLK)
    begin
        if (SYS_RST || !mid_on_q)
        begin
            settle_cnt_q <= '0;
            settled_q <= 1'b0;
        end
        else if (settle_cnt_q != CNT_W'(SETTLE_CYCLES))
        begin
            settle_cnt_q <= settle_cnt_q + 1'b1;
            settled_q <= 1'b0;
        end
        else
        begin
            settled_q <= 1'b1;
        end
    end

    assign wr_go = aw_held_q && w_held_q && !bvalid_q;

    // Write address and data may arrive in either order
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            aw_held_q <= 1'b0;
            awaddr_q <= '0;
            awready_q <= 1'b1;
        end
        else if (S_AXI_AWVALID && awready_q)
        begin
            aw_held_q <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
            awready_q <= 1'b0;
        end
        else if (wr_go)
            aw_held_q <= 1'b0;
        else if (bvalid_q && S_AXI_BREADY)
            awready_q <= 1'b1;
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            w_held_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
            wready_q <= 1'b1;
        end
        else if (S_AXI_WVALID && wready_q)
        begin
            w_held_q <= 1'b1;
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
            wready_q <= 1'b0;
        end
        else if (wr_go)
            w_held_q <= 1'b0;
        else if (bvalid_q && S_AXI_BREADY)
            wready_q <= 1'b1;
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            if (addr_is(awaddr_q, CTRL_OFFSET) || addr_is(awaddr_q, STATUS_OFFSET))
                bresp_q <= RESP_OKAY;
            else
                bresp_q <= RESP_SLVERR;
        end
        else if (bvalid_q && S_AXI_BREADY)
            bvalid_q <= 1'b0;
    end

    // Only the low byte holds control bits; status writes are ignored
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            ctrl_q <= CTRL_RESET;
        else if (wr_go && addr_is(awaddr_q, CTRL_OFFSET) && wstrb_q[0])
            ctrl_q <= wdata_q[CTRL_W-1:0];
    end

    always_comb
    begin
        status_word = '0;
        status_word[STAT_GND_LSB +: CH_NUM] = ground_q;
        status_word[STAT_SAMPLE_LSB +: CH_NUM] = sample_q;
        status_word[STAT_ROUTE_LSB +: CH_NUM] = route_q;
        status_word[STAT_DIRECT_LSB +: CH_NUM] = direct_q;
        status_word[STAT_DAMP_LSB +: CH_NUM] = damp_q;
        status_word[STAT_COM_MID_BIT] = com_mid_q;
        status_word[STAT_COM_GND_BIT] = com_gnd_q;
        status_word[STAT_MID_ON_BIT] = mid_on_q;
        status_word[STAT_SETTLED_BIT] = settled_q;
        status_word[STAT_MODE_LSB +: 2] = mode_q;
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end
        else if (S_AXI_ARVALID && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            if (addr_is(S_AXI_ARADDR, CTRL_OFFSET))
                rdata_q <= {{(32 - CTRL_W){1'b0}}, ctrl_q};
            else if (addr_is(S_AXI_ARADDR, STATUS_OFFSET))
                rdata_q <= status_word;
            else
            begin
                rdata_q <= '0;
                rresp_q <= RESP_SLVERR;
            end
        end
        else if (rvalid_q && S_AXI_RREADY)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = wready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;
    assign CH_TO_GROUND = ground_q;
    assign CH_DAMP = damp_q;
    assign SAMPLE_CLOSE = sample_q;
    assign CH_TO_COMPARATOR = route_q;
    assign DIRECT_TO_COMPARATOR = direct_q;
    assign COM_TO_MID = com_mid_q;
    assign COM_TO_GROUND = com_gnd_q;
    assign MID_VOLTAGE_ON = mid_on_q;

    // Configuration views for the checks, taken straight from the bits
    logic exc_cfg;
    logic smp_cfg;
    logic dir_cfg;
    logic undef_cfg;
    assign dir_cfg = ctrl_q[CTRL_DIR_BIT];
    assign exc_cfg = !dir_cfg && ctrl_q[CTRL_EXC_BIT] && !ctrl_q[CTRL_SHS_BIT];
    assign smp_cfg = !dir_cfg && ctrl_q[CTRL_SHS_BIT] && !ctrl_q[CTRL_EXC_BIT];
    assign undef_cfg = !dir_cfg && ctrl_q[CTRL_SHS_BIT] && ctrl_q[CTRL_EXC_BIT];

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_excite_pulse;
        exc_cfg && EXCITE_STROBE && OSCILLATOR_RELEASE_STROBE;
    endsequence

    sequence s_excite_fall;
        s_excite_pulse ##1 (exc_cfg && !EXCITE_STROBE);
    endsequence

    a_exc_no_sample: assert property (exc_cfg |=> SAMPLE_CLOSE == '0 && !COM_TO_GROUND)
        else $error("sampling switch active in excitation mode");

    a_exc_drive_one: assert property (s_excite_pulse |=>
        CH_TO_GROUND == ch_onehot($past(CHANNEL_SELECT_STROBE)) && COM_TO_MID)
        else $error("excitation did not ground the selected channel");

    a_release_gates: assert property (!OSCILLATOR_RELEASE_STROBE |=>
        CH_TO_GROUND == '0 && !COM_TO_MID)
        else $error("channel driven while release strobe low");

    a_excite_fall: assert property (s_excite_fall |=> CH_TO_GROUND == '0 && !COM_TO_MID)
        else $error("channel not released after excite fell");

    a_mid_follow: assert property (##1 MID_VOLTAGE_ON ==
        ($past(ctrl_q[CTRL_MID_BIT]) && !$past(ctrl_q[CTRL_SHS_BIT] && !ctrl_q[CTRL_EXC_BIT])))
        else $error("mid-voltage generator does not follow its enable");

    a_sample_mode_off: assert property (smp_cfg |=> !MID_VOLTAGE_ON && !COM_TO_MID
        && CH_TO_GROUND == '0)
        else $error("excitation active in sample-and-hold mode");

    a_sample_all: assert property (smp_cfg && EXCITE_STROBE |=>
        SAMPLE_CLOSE == '1 && COM_TO_GROUND)
        else $error("simultaneous sample incomplete");

    a_sample_open: assert property (smp_cfg && !EXCITE_STROBE |=>
        SAMPLE_CLOSE == '0 && !COM_TO_GROUND)
        else $error("sampling switches not opened");

    a_route_one_ch: assert property ((exc_cfg || smp_cfg) |=>
        CH_TO_COMPARATOR == ch_onehot($past(CHANNEL_SELECT_STROBE)) && DIRECT_TO_COMPARATOR == '0)
        else $error("channel routing not one-hot on selected channel");

    a_direct_wins: assert property (dir_cfg |=> CH_TO_COMPARATOR == '0 &&
        DIRECT_TO_COMPARATOR == ch_onehot($past(CHANNEL_SELECT_STROBE)) && SAMPLE_CLOSE == '0)
        else $error("direct input not selected");

    a_undef_quiet: assert property (undef_cfg |=> CH_TO_GROUND == '0 && SAMPLE_CLOSE == '0
        && !COM_TO_MID && !COM_TO_GROUND && CH_TO_COMPARATOR == '0)
        else $error("switches active in undefined mode");

    a_damp_all: assert property (exc_cfg && !OSCILLATOR_RELEASE_STROBE |=> CH_DAMP == '1)
        else $error("sensors not damped while release strobe low");

    a_bvalid_time: assert property (wr_go |=> S_AXI_BVALID)
        else $error("write response late");

endmodule

// File: hw/afe_switch_decode.sv
`timescale 1ns/1ps
module afe_switch_decode
    import afe_switch_pkg::*;
(
    input wire logic excitation_enable, // Excitation path configured
    input wire logic sample_hold_select, // Sample-and-hold path configured
    input wire logic mid_voltage_enable, // Mid-voltage generator requested
    input wire logic direct_input_select, // Direct inputs to comparator
    input wire logic excite_strobe, // Excite / sample strobe
    input wire logic oscillator_release_strobe, // High lets sensors run
    input wire logic [CH_SEL_W-1:0] channel_select_strobe, // Channel number
    output afe_mode_type mode, // Active path
    output logic [CH_NUM-1:0] ch_ground, // Channel input to analog ground
    output logic [CH_NUM-1:0] ch_damp, // Channel shorted for damping
    output logic [CH_NUM-1:0] sample_close, // Sampling switches
    output logic [CH_NUM-1:0] ch_route, // Held/sensed channel to comparator
    output logic [CH_NUM-1:0] direct_route, // Direct input to comparator
    output logic com_to_mid, // Common return to mid-voltage source
    output logic com_to_ground, // Common return to analog ground
    output logic mid_on // Mid-voltage generator on
);

    logic [CH_NUM-1:0] sel;
    logic exc_m;
    logic smp_m;
    logic drive;

    always_comb
    begin
        if (direct_input_select)
            mode = MODE_DIRECT;
        else if (excitation_enable && !sample_hold_select)
            mode = MODE_EXCITE;
        else if (sample_hold_select && !excitation_enable)
            mode = MODE_SAMPLE;
        else
            mode = MODE_OFF;
    end

    assign sel = ch_onehot(channel_select_strobe);
    assign exc_m = (mode == MODE_EXCITE);
    assign smp_m = (mode == MODE_SAMPLE);
    // Excitation needs both strobes; a falling excite frees the sensor
    assign drive = exc_m && excite_strobe && oscillator_release_strobe;

    assign com_to_mid = drive;
    assign com_to_ground = smp_m && excite_strobe;
    // Sample mode turns the generator off whatever software asked
    assign mid_on = mid_voltage_enable && !(sample_hold_select && !excitation_enable);

    genvar i;
    generate
        for (i = 0; i < CH_NUM; i++)
        begin : g_ch
            assign ch_ground[i] = drive && sel[i];
            // In excitation mode a low release strobe shorts every LC sensor between measurements
            assign ch_damp[i] = exc_m && !oscillator_release_strobe;
            assign sample_close[i] = smp_m && excite_strobe;
            assign ch_route[i] = (exc_m || smp_m) && sel[i];
            assign direct_route[i] = (mode == MODE_DIRECT) && sel[i];
        end
    endgenerate

endmodule

// File: hw/afe_switch_pkg.sv
package afe_switch_pkg;

    localparam int AXI_ADDR_W = 8;
    localparam int CH_NUM = 4;
    localparam int CH_SEL_W = 2;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // Control register fields
    localparam int CTRL_EXC_BIT = 0;
    localparam int CTRL_SHS_BIT = 1;
    localparam int CTRL_MID_BIT = 2;
    localparam int CTRL_DIR_BIT = 3;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // Status register fields
    localparam int STAT_GND_LSB = 0;
    localparam int STAT_SAMPLE_LSB = 4;
    localparam int STAT_ROUTE_LSB = 8;
    localparam int STAT_DIRECT_LSB = 12;
    localparam int STAT_DAMP_LSB = 16;
    localparam int STAT_COM_MID_BIT = 20;
    localparam int STAT_COM_GND_BIT = 21;
    localparam int STAT_MID_ON_BIT = 22;
    localparam int STAT_SETTLED_BIT = 23;
    localparam int STAT_MODE_LSB = 24;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Mid-voltage settling
    localparam int CLK_HZ = 20000000;
    localparam int MID_SETTLE_US = 6000;
    localparam int MID_SETTLE_CYCLES = MID_SETTLE_US * (CLK_HZ / 1000000);

    typedef enum logic [1:0]
    {
        MODE_OFF = 2'b00,
        MODE_EXCITE = 2'b01,
        MODE_SAMPLE = 2'b10,
        MODE_DIRECT = 2'b11
    } afe_mode_type;

    function automatic logic [CH_NUM-1:0] ch_onehot(input logic [CH_SEL_W-1:0] sel);
        ch_onehot = 4'h1 << sel;
    endfunction

endpackage

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    import afe_switch_pkg::*;
    localparam int SETTLE = 8;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic go = 1'b0;
    logic fault = 1'b0;
    logic [1:0] fch = 2'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awv = 1'b0;
    logic wv = 1'b0;
    logic arv = 1'b0;
    logic bready = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, com_mid, com_gnd, mid_on, ex, rel, busy;
    logic [1:0] bresp, rresp, sel;
    logic [31:0] rdata;
    logic [3:0] gnd, damp, smp, rte, dirr;
    logic [3:0] ctrl_exp = 4'h0;
    logic chk_on = 1'b0;
    logic ex_p = 1'b0;
    logic rel_p = 1'b0;
    logic [1:0] sel_p = 2'h0;
    logic [22:0] exp_sw;
    int err_count = 0;
    int checks_done = 0;
    wire logic [22:0] obs = {gnd, damp, smp, rte, dirr, com_mid, com_gnd, mid_on};

    initial
    begin
        forever #25 clk = ~clk;
    end

    afe_switch_ctrl #(.SETTLE_CYCLES(SETTLE)) uut
    (
        .CLK(clk), .SYS_RST(sys_rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready),
        .EXCITE_STROBE(ex), .OSCILLATOR_RELEASE_STROBE(rel), .CHANNEL_SELECT_STROBE(sel),
        .CH_TO_GROUND(gnd), .CH_DAMP(damp), .SAMPLE_CLOSE(smp), .CH_TO_COMPARATOR(rte),
        .DIRECT_TO_COMPARATOR(dirr), .COM_TO_MID(com_mid), .COM_TO_GROUND(com_gnd),
        .MID_VOLTAGE_ON(mid_on)
    );

    tsm_partner partner
    (
        .clk(clk), .rst(sys_rst), .go(go), .no_release(fault), .ch(fch),
        .excite(ex), .rel_strobe(rel), .sel(sel), .busy(busy)
    );

    // Control bits: 0 excitation, 1 sample-hold, 2 mid-voltage, 3 direct
    function automatic logic [22:0] exp_out(input logic [3:0] c, input logic e,
                                            input logic r, input logic [1:0] s);
        logic [3:0] oh, g, d, sm, rt, di;
        logic cm, cg, m;
        oh = 4'h1 << s;
        {g, d, sm, rt, di, cm, cg} = 22'h0;
        m = c[2] & ~(c[1] & ~c[0]);
        if (c[3])
            di = oh;
        else if (c[0] & ~c[1])
        begin
            g = (e & r) ? oh : 4'h0;
            cm = e & r;
            d = r ? 4'h0 : 4'hf;
            rt = oh;
        end
        else if (c[1] & ~c[0])
        begin
            sm = e ? 4'hf : 4'h0;
            cg = e;
            rt = oh;
        end
        exp_out = {g, d, sm, rt, di, cm, cg, m};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic hang();
        err_count++;
        $display("BAD %0t no answer within bound", $time);
        report_and_stop();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        int n;
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50 && !(ad && wd); n++)
        begin
            @(posedge clk);
            ad = ad | (awv & awready);
            wd = wd | (wv & wready);
            awv <= !ad;
            wv <= !wd;
        end
        for (; n < 100 && bvalid !== 1'b1; n++)
            @(posedge clk);
        if (n >= 100)
            hang();
        chk({30'h0, bresp}, {30'h0, r}, "write response");
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic [1:0] r);
        int n;
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50 && (arv !== 1'b1 || arready !== 1'b1); n++)
            @(posedge clk);
        arv <= 1'b0;
        for (; n < 100 && rvalid !== 1'b1; n++)
            @(posedge clk);
        if (n >= 100)
            hang();
        chk(rdata & m, e, "read data");
        chk({30'h0, rresp}, {30'h0, r}, "read response");
        rready <= 1'b0;
        @(posedge clk);
    endtask

    // The switch monitor pauses while the control word is in flight
    task automatic set_ctrl(input logic [3:0] v);
        chk_on <= 1'b0;
        wr(CTRL_OFFSET, {28'h0, v}, 4'hf, RESP_OKAY);
        ctrl_exp <= v;
        repeat (2) @(posedge clk);
        chk_on <= 1'b1;
    endtask

    task automatic frame(input logic [1:0] c, input logic f);
        int n;
        logic seen;
        seen = 1'b0;
        fch <= c;
        fault <= f;
        go <= 1'b1;
        for (n = 0; n < 20 && !(seen && busy !== 1'b1); n++)
        begin
            @(posedge clk);
            if (!seen)
                go <= 1'b0;
            seen = seen | (busy === 1'b1);
        end
        if (n >= 20)
            hang();
    endtask

    // Outputs are registered: compare against strobes seen one edge earlier
    always @(posedge clk)
    begin
        if (chk_on)
        begin
            exp_sw = exp_out(ctrl_exp, ex_p, rel_p, sel_p);
            chk({28'h0, obs[22:19]}, {28'h0, exp_sw[22:19]}, "ground");
            chk({24'h0, obs[14:7]}, {24'h0, exp_sw[14:7]}, "route");
            chk({9'h0, obs}, {9'h0, exp_sw}, "switches");
        end
        ex_p <= ex;
        rel_p <= rel;
        sel_p <= sel;
    end

    initial
    begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(CTRL_OFFSET, 32'h0, 32'hffffffff, RESP_OKAY);
        rd(STATUS_OFFSET, 32'h0, 32'hffffffff, RESP_OKAY);
        rd(8'h08, 32'h0, 32'hffffffff, RESP_SLVERR);
        wr(8'h10, 32'h1, 4'hf, RESP_SLVERR);
        wr(STATUS_OFFSET, 32'hf, 4'hf, RESP_OKAY);
        wr(CTRL_OFFSET, 32'h9, 4'h0, RESP_OKAY);
        rd(CTRL_OFFSET, 32'h0, 32'hffffffff, RESP_OKAY);
        $display("test registers done");
        for (int v = 0; v < 16; v++)
        begin
            set_ctrl(v[3:0]);
            rd(CTRL_OFFSET, {28'h0, v[3:0]}, 32'hffffffff, RESP_OKAY);
            for (int c = 0; c < 4; c++)
                frame(c[1:0], 1'b0);
            frame(2'h1, 1'b1);
        end
        $display("test modes done");
        // Generator off first, so the settling count restarts from zero
        set_ctrl(4'h6);
        rd(STATUS_OFFSET, 32'h02000000, 32'h03c00000, RESP_OKAY);
        set_ctrl(4'h5);
        rd(STATUS_OFFSET, 32'h01400000, 32'h03c00000, RESP_OKAY);
        repeat (SETTLE + 4) @(posedge clk);
        rd(STATUS_OFFSET, 32'h01c00000, 32'h03c00000, RESP_OKAY);
        set_ctrl(4'hc);
        rd(STATUS_OFFSET, 32'h03400000, 32'h03400000, RESP_OKAY);
        $display("test mid voltage done");
        report_and_stop();
    end
endmodule

// File: verif/tsm_partner.sv
`timescale 1ns/1ps
module tsm_partner
(
    input wire logic clk, // Bench clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic go, // Start one measurement frame
    input wire logic no_release, // Faulty frame: release strobe never rises
    input wire logic [1:0] ch, // Channel measured in the frame
    output logic excite, // Excite strobe
    output logic rel_strobe, // Oscillator release strobe
    output logic [1:0] sel, // Channel select strobe
    output logic busy // Frame in progress
);
    logic [2:0] step_q = 3'h0;
    logic [1:0] sel_q = 2'h0;
    logic fault_q = 1'b0;
    // Steps 1-2 excite, 3-5 free oscillation, 6 damping before the next frame
    assign excite = (step_q == 3'h1) || (step_q == 3'h2);
    assign rel_strobe = (step_q != 3'h0) && (step_q < 3'h6) && !fault_q;
    assign busy = step_q != 3'h0;
    assign sel = sel_q;
    always_ff @(posedge clk)
    begin
        if (rst)
            step_q <= 3'h0;
        else if (step_q == 3'h6)
            step_q <= 3'h0;
        else if (step_q != 3'h0 || go)
            step_q <= step_q + 3'h1;
    end
    // Select is a level that a real sequencer leaves in place between frames
    always_ff @(posedge clk)
    begin
        if (step_q == 3'h0 && go)
        begin
            sel_q <= ch;
            fault_q <= no_release;
        end
    end
endmodule
